// *** verilog/frc_pkg.sv ***
package frc_pkg;
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_STATUS_CURRENT = 8'h7B;
	localparam logic [7:0] CMD_OC_RESPONSE = 8'hE5;
	localparam logic [7:0] CMD_UC_RESPONSE = 8'hE6;
	localparam logic [7:0] CMD_AVG_OC_LIMIT = 8'hE7;
	localparam logic [7:0] CMD_DRIVE_IO = 8'hE9;
	localparam int RESP_MODE_HI = 7;
	localparam int RESP_MODE_LO = 6;
	localparam int RETRY_HI = 5;
	localparam int RETRY_LO = 3;
	localparam int DELAY_HI = 2;
	localparam int DELAY_LO = 0;
	localparam logic [1:0] RESP_MODE_SHUTDOWN = 2'h2;
	localparam logic [2:0] RETRY_NONE = 3'h0;
	localparam int STAT_OC_BIT = 7;
	localparam int STAT_UC_BIT = 4;
	localparam int DRV_GATE_OFF_BIT = 2;
	localparam int DRV_IO_LEVEL_BIT = 1;
	localparam int DRV_MID_LEVEL_BIT = 0;
	localparam logic [7:0] DRV_RESET = 8'h01;
	localparam logic [7:0] DRV_WRITABLE = 8'h07;
	localparam int LIN_EXP_HI = 15;
	localparam int LIN_EXP_LO = 11;
	localparam int LIN_MANT_HI = 10;
	localparam int FIX_FRAC_BITS = 4;
	localparam logic [11:0] AVG_LIMIT_MAX_FIX = 12'h640;
	localparam logic [7:0] STRAP_OFFSET_AMPS = 8'h05;
	localparam logic [4:0] AVG_DEFAULT_EXP = 5'h1E;
	localparam logic [11:0] AVG_DEFAULT_DIV = 12'h005;
	localparam int CLK_PERIOD_NS = 100;
	localparam int RETRY_UNIT_NS = 35000000;
	localparam int RETRY_UNIT_CYCLES = RETRY_UNIT_NS / CLK_PERIOD_NS;
	localparam logic [7:0] BLANK_SAMPLES = 8'h02;
	typedef enum logic [1:0] {FRC_OFF, FRC_RUN, FRC_LATCHED, FRC_RETRY} frc_mode_t;
endpackage : frc_pkg

// *** verilog/frc_fault_response.sv ***
module frc_fault_response #(
	parameter int TICK_CYCLES = frc_pkg::RETRY_UNIT_CYCLES // Clocks per 35 ms retry tick.
) (
	input wire logic clk, // Core clock, 10 MHz.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic cmdValid, // Command request strobe.
	input wire logic cmdWrite, // 1 write, 0 read.
	input wire logic [7:0] cmdCode, // Command code.
	input wire logic [15:0] cmdData, // Write data, low byte for one-byte commands.
	output logic cmdAck, // Command accepted, one cycle.
	output logic cmdNack, // Command refused, one cycle.
	output logic [15:0] rdData, // Read data, valid with cmdAck.
	input wire logic [7:0] ucRespStrap, // Strap default of the undercurrent response.
	input wire logic [7:0] ocRespStrap, // Strap default of the overcurrent response.
	input wire logic [7:0] peakLimitStrap, // Strap peak overcurrent limit in amps.
	input wire logic ucDetect, // Undercurrent fault detected.
	input wire logic ocPeakDetect, // Peak overcurrent fault detected.
	input wire logic sampleValid, // Current sample strobe.
	input wire logic [11:0] sampleCurrent, // Sample in 1/16 A.
	input wire logic switchOn, // High during the switch-on interval.
	input wire logic upSlopeSense, // 1 up-slope sensing, 0 down-slope.
	input wire logic cmdOff, // Output commanded off.
	input wire logic biasLost, // Bias power removed.
	input wire logic otherFaultOff, // Shutdown by another fault.
	output logic outputEnable, // Power stage output enabled.
	output logic restartPulse, // One-cycle pulse at each restart attempt.
	output logic busAlert_n, // Bus alert, active low.
	output logic gateRegulatorOff, // Gate-drive regulator disabled.
	output logic busIoLevelSelect, // 1 selects 1.8 V bus I/O levels.
	output logic driveMidLevelSelect // 1 selects the 1.5 V mid-drive level.
);
	import frc_pkg::*;

	typedef struct packed {
		frc_mode_t mode;
		logic outEn;
		logic restart;
		logic strapDone;
		logic [7:0] ucResp;
		logic [7:0] ocResp;
		logic [7:0] drvCfg;
		logic [15:0] avgLimit;
		logic statOc;
		logic statUc;
		logic alertN;
		logic [18:0] tickCnt;
		logic [2:0] unitCnt;
		logic [2:0] delay;
		logic phasePrev;
		logic [7:0] blankCnt;
		logic [7:0] sampleCnt;
		logic [19:0] sampleSum;
		logic ack;
		logic nack;
		logic [15:0] rdData;
	} frc_state_t;

	frc_state_t state_r;
	frc_state_t state_nxt;
	logic [12:0] limFix;
	logic [12:0] wrFix;
	logic phaseNow;
	logic avgTrip;
	logic ocEvent;
	logic clearCmd;
	logic stopCmd;
	logic [7:0] resp;
	logic shut;
	logic tick;
	logic expiry;
	logic [11:0] avgDefault;
	logic [7:0] statusByte;

	// Bit 12 flags a value outside 0 A to 100 A; bits 11:0 give the value in 1/16 A.
	function automatic logic [12:0] lin11Fix(input logic [15:0] w);
		logic signed [39:0] v;
		int sh;
		v = {{29{w[LIN_MANT_HI]}}, w[LIN_MANT_HI:0]};
		sh = int'($signed(w[LIN_EXP_HI:LIN_EXP_LO])) + FIX_FRAC_BITS;
		if (sh >= 0) begin
			v = v <<< sh;
		end else begin
			v = v >>> (-sh);
		end
		if (v < 0 || v > $signed({28'h0000000, AVG_LIMIT_MAX_FIX})) begin
			lin11Fix = {1'b1, 12'h000};
		end else begin
			lin11Fix = {1'b0, v[11:0]};
		end
	endfunction : lin11Fix

	assign limFix = lin11Fix(state_r.avgLimit);
	assign wrFix = lin11Fix(cmdData);
	// The compared phase follows the sensing slope.
	assign phaseNow = upSlopeSense ? switchOn : !switchOn;
	// Sum against threshold times count avoids a divider for the average.
	assign avgTrip = !phaseNow && state_r.phasePrev && state_r.sampleCnt != 8'h00
		&& !limFix[12]
		&& state_r.sampleSum > 20'(limFix[11:0]) * 20'(state_r.sampleCnt);
	assign ocEvent = ocPeakDetect || avgTrip;
	assign clearCmd = cmdValid && cmdWrite && cmdCode == CMD_CLEAR_FAULTS && state_r.strapDone;
	assign stopCmd = cmdOff || biasLost || otherFaultOff;
	// Overcurrent takes its own response register, even with undercurrent in the same cycle; undercurrent alone the other.
	assign resp = ocEvent ? state_r.ocResp : state_r.ucResp;
	assign shut = (ocEvent || ucDetect)
		&& resp[RESP_MODE_HI:RESP_MODE_LO] == RESP_MODE_SHUTDOWN;
	assign tick = state_r.tickCnt == 19'(TICK_CYCLES - 1);
	assign expiry = state_r.mode == FRC_RETRY && tick && state_r.unitCnt == state_r.delay;
	// A strap below 5 A yields a zero threshold rather than a negative one.
	assign avgDefault = (peakLimitStrap > STRAP_OFFSET_AMPS)
		? {peakLimitStrap - STRAP_OFFSET_AMPS, 4'h0} / AVG_DEFAULT_DIV : 12'h000;
	assign statusByte = ({7'h00, state_r.statOc} << STAT_OC_BIT)
		| ({7'h00, state_r.statUc} << STAT_UC_BIT);

	always_comb begin
		state_nxt = state_r;
		state_nxt.restart = 1'b0;
		state_nxt.ack = 1'b0;
		state_nxt.nack = 1'b0;
		state_nxt.phasePrev = phaseNow;
		// Averaging window, with leading samples dropped as blanking.
		if (phaseNow && !state_r.phasePrev) begin
			state_nxt.sampleSum = 20'h00000;
			state_nxt.sampleCnt = 8'h00;
			state_nxt.blankCnt = 8'h00;
		end else if (phaseNow && sampleValid) begin
			if (state_r.blankCnt < BLANK_SAMPLES) begin
				state_nxt.blankCnt = state_r.blankCnt + 8'h01;
			end else if (state_r.sampleCnt != 8'hFF) begin
				state_nxt.sampleSum = state_r.sampleSum + 20'(sampleCurrent);
				state_nxt.sampleCnt = state_r.sampleCnt + 8'h01;
			end
		end
		// An event in the clearing cycle wins over the clear.
		state_nxt.statOc = ocEvent || (state_r.statOc && !clearCmd);
		state_nxt.statUc = ucDetect || (state_r.statUc && !clearCmd);
		state_nxt.alertN = !(state_nxt.statOc || state_nxt.statUc);
		if (state_r.mode == FRC_RETRY) begin
			state_nxt.tickCnt = tick ? 19'h00000 : state_r.tickCnt + 19'h00001;
			if (tick) begin
				state_nxt.unitCnt = state_r.unitCnt + 3'h1;
			end
		end
		if (stopCmd) begin
			state_nxt.mode = FRC_OFF;
			state_nxt.outEn = 1'b0;
		end else begin
			case (state_r.mode)
				FRC_OFF: begin
					state_nxt.mode = FRC_RUN;
					state_nxt.outEn = 1'b1;
				end
				FRC_RUN: begin
					if (shut) begin
						state_nxt.outEn = 1'b0;
						state_nxt.delay = resp[DELAY_HI:DELAY_LO];
						state_nxt.tickCnt = 19'h00000;
						state_nxt.unitCnt = 3'h0;
						if (resp[RETRY_HI:RETRY_LO] == RETRY_NONE) begin
							state_nxt.mode = FRC_LATCHED;
						end else begin
							state_nxt.mode = FRC_RETRY;
						end
					end
				end
				FRC_LATCHED: begin
					// A fault with a shutdown response landing with the clear keeps the output off, as the set wins.
					if (clearCmd && !shut) begin
						state_nxt.mode = FRC_RUN;
						state_nxt.outEn = 1'b1;
					end
				end
				FRC_RETRY: begin
					// A fault with a shutdown response still present at expiry keeps the output off and skips that restart.
					if (shut) begin
						state_nxt.outEn = 1'b0;
					end else if (expiry) begin
						if (state_r.outEn) begin
							state_nxt.mode = FRC_RUN;
						end else begin
							state_nxt.outEn = 1'b1;
							state_nxt.restart = 1'b1;
							state_nxt.tickCnt = 19'h00000;
							state_nxt.unitCnt = 3'h0;
						end
					end
				end
				default: begin
					state_nxt.mode = FRC_OFF;
				end
			endcase
		end
		if (cmdValid && state_r.strapDone) begin
			state_nxt.ack = 1'b1;
			if (cmdWrite) begin
				if (cmdCode == CMD_OC_RESPONSE) begin
					state_nxt.ocResp = cmdData[7:0];
				end else if (cmdCode == CMD_UC_RESPONSE) begin
					state_nxt.ucResp = cmdData[7:0];
				end else if (cmdCode == CMD_AVG_OC_LIMIT) begin
					if (wrFix[12]) begin
						state_nxt.ack = 1'b0;
						state_nxt.nack = 1'b1;
					end else begin
						state_nxt.avgLimit = cmdData;
					end
				end else if (cmdCode == CMD_DRIVE_IO) begin
					state_nxt.drvCfg = cmdData[7:0] & DRV_WRITABLE;
				end else if (cmdCode != CMD_CLEAR_FAULTS) begin
					state_nxt.ack = 1'b0;
					state_nxt.nack = 1'b1;
				end
			end else begin
				if (cmdCode == CMD_OC_RESPONSE) begin
					state_nxt.rdData = {8'h00, state_r.ocResp};
				end else if (cmdCode == CMD_UC_RESPONSE) begin
					state_nxt.rdData = {8'h00, state_r.ucResp};
				end else if (cmdCode == CMD_AVG_OC_LIMIT) begin
					state_nxt.rdData = state_r.avgLimit;
				end else if (cmdCode == CMD_DRIVE_IO) begin
					state_nxt.rdData = {8'h00, state_r.drvCfg};
				end else if (cmdCode == CMD_STATUS_CURRENT) begin
					state_nxt.rdData = {8'h00, statusByte};
				end else begin
					state_nxt.ack = 1'b0;
					state_nxt.nack = 1'b1;
				end
			end
		end
		// Straps are caught on the first edge after reset release, never under reset.
		if (!state_r.strapDone) begin
			state_nxt.strapDone = 1'b1;
			state_nxt.ucResp = ucRespStrap;
			state_nxt.ocResp = ocRespStrap;
			state_nxt.avgLimit = {AVG_DEFAULT_EXP, avgDefault[10:0]};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= '0;
			state_r.alertN <= 1'b1;
			state_r.drvCfg <= DRV_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign cmdAck = state_r.ack;
	assign cmdNack = state_r.nack;
	assign rdData = state_r.rdData;
	assign outputEnable = state_r.outEn;
	assign restartPulse = state_r.restart;
	assign busAlert_n = state_r.alertN;
	assign gateRegulatorOff = state_r.drvCfg[DRV_GATE_OFF_BIT];
	assign busIoLevelSelect = state_r.drvCfg[DRV_IO_LEVEL_BIT];
	assign driveMidLevelSelect = state_r.drvCfg[DRV_MID_LEVEL_BIT];

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	AST_UC_ALERT: assert property (ucDetect |=> !busAlert_n && state_r.statUc)
		else $error("Undercurrent fault did not raise alert and status.");
	AST_UC_NOT_OC: assert property (!ocEvent |=> !$rose(state_r.statOc))
		else $error("Overcurrent status rose without an overcurrent event.");
	AST_STICKY: assert property (state_r.statUc && !clearCmd |=> state_r.statUc)
		else $error("Undercurrent status cleared without clear command.");
	AST_CLEAR: assert property (clearCmd && !ucDetect && !ocEvent
		|=> busAlert_n && statusByte == 8'h00)
		else $error("Clear command left a fault bit or alert.");
	AST_SHUT_NOW: assert property (shut && state_r.mode != FRC_OFF |=> !outputEnable)
		else $error("Output not disabled on the cycle after a fault.");
	AST_LATCHED: assert property (state_r.mode == FRC_LATCHED && !clearCmd
		|=> !outputEnable)
		else $error("Output came back without a clear in no-retry mode.");
	AST_STOP: assert property (stopCmd |=> !outputEnable && state_r.mode == FRC_OFF)
		else $error("Output stayed on after off command or bias loss.");
	AST_RETRY_TIME: assert property (restartPulse |-> $past(tick)
		&& $past(state_r.unitCnt) == $past(state_r.delay))
		else $error("Restart attempt at the wrong delay.");
	AST_AVG_TRIP: assert property (avgTrip |=> state_r.statOc && !busAlert_n)
		else $error("Average overcurrent did not set overcurrent status.");
	AST_REJECT: assert property (cmdValid && cmdWrite && cmdCode == CMD_AVG_OC_LIMIT
		&& wrFix[12] && state_r.strapDone |=> cmdNack && $stable(state_r.avgLimit))
		else $error("Out-of-range threshold write was taken.");
	AST_RESERVED: assert property (state_r.drvCfg[7:3] == 5'h00)
		else $error("Reserved setting bits are not zero.");
	AST_SET_WINS: assert property (ucDetect && clearCmd |=> state_r.statUc && !busAlert_n)
		else $error("Clear command won over a fault in the same cycle.");
	AST_RESTART_ON: assert property (restartPulse |-> outputEnable)
		else $error("Restart attempt without the output enabled.");
	AST_NO_RETRY: assert property (state_r.mode == FRC_RUN && shut && !stopCmd
		&& resp[RETRY_HI:RETRY_LO] == RETRY_NONE |=> state_r.mode == FRC_LATCHED)
		else $error("No-retry shutdown did not latch the output off.");
	AST_UC_WRITE: assert property (cmdValid && cmdWrite && cmdCode == CMD_UC_RESPONSE
		&& state_r.strapDone |=> state_r.ucResp == 8'($past(cmdData)))
		else $error("Undercurrent response write was not stored.");
	AST_OC_USES_OC: assert property (state_r.mode == FRC_RUN && ocEvent && !stopCmd
		&& state_r.ocResp[RESP_MODE_HI:RESP_MODE_LO] == RESP_MODE_SHUTDOWN
		|=> !outputEnable)
		else $error("Overcurrent did not follow its own response register.");
endmodule : frc_fault_response

// *** sim/frc_host_model.sv ***
module frc_host_model (
	input wire logic clk, // Core clock.
	input wire logic cmdAck, // Accept pulse from the device.
	input wire logic cmdNack, // Refuse pulse from the device.
	input wire logic [15:0] rdData, // Read data from the device.
	output logic cmdValid, // Request strobe.
	output logic cmdWrite, // Write select.
	output logic [7:0] cmdCode, // Command code.
	output logic [15:0] cmdData // Write data.
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cmdValid = 1'b0;
		cmdWrite = 1'b0;
		cmdCode = 8'hFF;
		cmdData = 16'hFFFF;
	end
	// Idle lines carry the inverse of the last request, so a stale value never looks valid.
	task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
		output logic ack, output logic nack, output logic [15:0] rd);
		@(posedge clk);
		#1;
		cmdValid = 1'b1;
		cmdWrite = w;
		cmdCode = c;
		cmdData = d;
		@(posedge clk);
		#1;
		cmdValid = 1'b0;
		cmdWrite = ~w;
		cmdCode = ~c;
		cmdData = ~d;
		ack = cmdAck;
		nack = cmdNack;
		rd = rdData;
	endtask : xfer
endmodule : frc_host_model

// *** sim/tb_top.sv ***
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import frc_pkg::*;
	localparam int TICK = 10;
	logic clk, rst_n, cmdValid, cmdWrite, cmdAck, cmdNack, ack, nack;
	logic [7:0] cmdCode, ucRespStrap, ocRespStrap, peakLimitStrap;
	logic [15:0] cmdData, rdData, rd, v, lim;
	logic ucDetect, ocPeakDetect, sampleValid, switchOn, upSlopeSense;
	logic cmdOff, biasLost, otherFaultOff, outputEnable, restartPulse, busAlert_n;
	logic gateRegulatorOff, busIoLevelSelect, driveMidLevelSelect;
	logic [11:0] sampleCurrent;
	logic [11:0] curs [3] = '{12'h008, 12'h010, 12'h011};
	int num_errors, n_tests, seed, n;
	frc_fault_response #(.TICK_CYCLES(TICK)) frc_fault_response_i (.clk(clk), .rst_n(rst_n),
		.cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdData(cmdData),
		.cmdAck(cmdAck), .cmdNack(cmdNack), .rdData(rdData), .ucRespStrap(ucRespStrap),
		.ocRespStrap(ocRespStrap), .peakLimitStrap(peakLimitStrap), .ucDetect(ucDetect),
		.ocPeakDetect(ocPeakDetect), .sampleValid(sampleValid), .sampleCurrent(sampleCurrent),
		.switchOn(switchOn), .upSlopeSense(upSlopeSense), .cmdOff(cmdOff), .biasLost(biasLost),
		.otherFaultOff(otherFaultOff), .outputEnable(outputEnable), .restartPulse(restartPulse),
		.busAlert_n(busAlert_n), .gateRegulatorOff(gateRegulatorOff),
		.busIoLevelSelect(busIoLevelSelect), .driveMidLevelSelect(driveMidLevelSelect));
	frc_host_model frc_host_model_i (.clk(clk), .cmdAck(cmdAck), .cmdNack(cmdNack),
		.rdData(rdData), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
		.cmdData(cmdData));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic stop_test();
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : stop_test
	task automatic chk1(input string nm, input logic exp, input logic got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %b seen %b", nm, exp, got);
		end
	endtask : chk1
	task automatic chk16(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk16
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : cyc
	task automatic wrchk(input logic [7:0] c, input logic [15:0] d, input logic expAck);
		frc_host_model_i.xfer(1'b1, c, d, ack, nack, rd);
		chk1("write ack", expAck, ack);
		chk1("write nack", ~expAck, nack);
	endtask : wrchk
	task automatic rdchk(input string nm, input logic [7:0] c, input logic [15:0] exp);
		frc_host_model_i.xfer(1'b0, c, 16'h0000, ack, nack, rd);
		chk1("read ack", 1'b1, ack);
		chk16(nm, exp, rd);
	endtask : rdchk
	task automatic ucPulse();
		@(posedge clk);
		#1;
		ucDetect = 1'b1;
		cyc(1);
		ucDetect = 1'b0;
	endtask : ucPulse
	task automatic samp(input logic [11:0] x, input int k);
		repeat (k) begin
			cyc(1);
			sampleValid = 1'b1;
			sampleCurrent = x;
		end
		cyc(1);
		sampleValid = 1'b0;
		sampleCurrent = ~x;
	endtask : samp
	// Large samples outside the sensed interval and in its blanking must never count.
	task automatic window(input logic m, input logic [11:0] cur, input logic [15:0] exp);
		upSlopeSense = m;
		switchOn = ~m;
		cyc(2);
		wrchk(CMD_CLEAR_FAULTS, 16'h0000, 1'b1);
		samp(12'hFFF, 3);
		switchOn = m;
		samp(12'hFFF, 2);
		samp(cur, 3);
		switchOn = ~m;
		cyc(3);
		rdchk("average trip", CMD_STATUS_CURRENT, exp);
	endtask : window
	function automatic logic accOk(input logic [15:0] w);
		int y;
		int e;
		longint q;
		y = $signed(w[10:0]);
		e = $signed(w[15:11]) + FIX_FRAC_BITS;
		q = (e >= 0) ? (longint'(y) <<< e) : (longint'(y) >>> (-e));
		return (y >= 0) && (q <= longint'(AVG_LIMIT_MAX_FIX));
	endfunction : accOk
	function automatic logic [15:0] avgDef(input logic [7:0] s);
		int y;
		y = (s > 8'h05) ? (16 * (int'(s) - 5)) / 5 : 0;
		return {AVG_DEFAULT_EXP, 11'(y)};
	endfunction : avgDef
	initial begin
		seed = 27;
		{num_errors, n_tests} = '0;
		{rst_n, ucDetect, ocPeakDetect, sampleValid, switchOn, upSlopeSense} = '0;
		{cmdOff, biasLost, otherFaultOff} = 3'h0;
		sampleCurrent = 12'h000;
		ucRespStrap = 8'($random(seed));
		ocRespStrap = 8'($random(seed));
		peakLimitStrap = 8'($random(seed));
		repeat (8) @(posedge clk);
		#1;
		rst_n = 1'b1;
		cyc(2);
		rdchk("settings reset", CMD_DRIVE_IO, 16'h0001);
		chk1("gate off reset", 1'b0, gateRegulatorOff);
		chk1("io level reset", 1'b0, busIoLevelSelect);
		chk1("mid level reset", 1'b1, driveMidLevelSelect);
		rdchk("uc response reset", CMD_UC_RESPONSE, {8'h00, ucRespStrap});
		rdchk("oc response reset", CMD_OC_RESPONSE, {8'h00, ocRespStrap});
		lim = avgDef(peakLimitStrap);
		rdchk("limit reset", CMD_AVG_OC_LIMIT, lim);
		wrchk(8'h55, 16'h0000, 1'b0);
		for (int i = 0; i < 8; i++) begin
			v = 16'($random(seed));
			wrchk(CMD_DRIVE_IO, v, 1'b1);
			rdchk("settings", CMD_DRIVE_IO, {8'h00, v[7:0] & DRV_WRITABLE});
			chk1("gate off", v[2], gateRegulatorOff);
			chk1("io level", v[1], busIoLevelSelect);
			chk1("mid level", v[0], driveMidLevelSelect);
			wrchk(CMD_UC_RESPONSE, v & 16'h003F, 1'b1);
			rdchk("uc response", CMD_UC_RESPONSE, v & 16'h003F);
		end
		for (int i = 0; i < 16; i++) begin
			v = 16'($random(seed));
			v[15:14] = {2{v[13]}};
			if (i == 0) v = 16'h0064;
			if (i == 1) v = 16'h0065;
			wrchk(CMD_AVG_OC_LIMIT, v, accOk(v));
			if (accOk(v)) lim = v;
			rdchk("limit", CMD_AVG_OC_LIMIT, lim);
		end
		wrchk(CMD_UC_RESPONSE, 16'h0080, 1'b1);
		ucPulse();
		chk1("uc shutdown", 1'b0, outputEnable);
		chk1("uc alert", 1'b0, busAlert_n);
		cyc(5 * TICK);
		chk1("uc latched", 1'b0, outputEnable);
		rdchk("uc status", CMD_STATUS_CURRENT, 16'h0010);
		wrchk(CMD_CLEAR_FAULTS, 16'h0000, 1'b1);
		chk1("alert cleared", 1'b1, busAlert_n);
		cyc(2);
		chk1("restart after clear", 1'b1, outputEnable);
		// Modes 00, 01 and 11 in turn, each with a retry setting that must stay unused.
		for (int k = 0; k < 3; k++) begin
			wrchk(CMD_UC_RESPONSE, {8'h00, 2'(k + k / 2), 6'h09}, 1'b1);
			ucPulse();
			chk1("unused mode output", 1'b1, outputEnable);
			chk1("unused mode alert", 1'b0, busAlert_n);
			wrchk(CMD_CLEAR_FAULTS, 16'h0000, 1'b1);
		end
		ucDetect = 1'b1;
		wrchk(CMD_CLEAR_FAULTS, 16'h0000, 1'b1);
		ucDetect = 1'b0;
		chk1("set wins over clear", 1'b0, busAlert_n);
		wrchk(CMD_CLEAR_FAULTS, 16'h0000, 1'b1);
		wrchk(CMD_UC_RESPONSE, 16'h0089, 1'b1);
		ucPulse();
		n = 0;
		while (restartPulse !== 1'b1 && n < 1000) begin
			cyc(1);
			n++;
		end
		if (n >= 1000) begin
			num_errors++;
			$display("MISMATCH restart wait expected pulse seen none");
			stop_test();
		end
		chk16("retry interval", 16'(2 * TICK), 16'(n));
		chk1("retry output", 1'b1, outputEnable);
		ucPulse();
		biasLost = 1'b1;
		n = 0;
		repeat (6 * TICK) begin
			cyc(1);
			if (restartPulse === 1'b1) n++;
		end
		chk16("retry after bias loss", 16'h0000, 16'(n));
		biasLost = 1'b0;
		wrchk(CMD_UC_RESPONSE, 16'h0080, 1'b1);
		wrchk(CMD_CLEAR_FAULTS, 16'h0000, 1'b1);
		for (int k = 0; k < 3; k++) begin
			{cmdOff, biasLost, otherFaultOff} = 3'h4 >> k;
			cyc(2);
			chk1("stop input", 1'b0, outputEnable);
			{cmdOff, biasLost, otherFaultOff} = 3'h0;
			cyc(3);
			chk1("stop released", 1'b1, outputEnable);
		end
		wrchk(CMD_OC_RESPONSE, 16'h0080, 1'b1);
		cyc(1);
		ocPeakDetect = 1'b1;
		cyc(1);
		ocPeakDetect = 1'b0;
		chk1("oc shutdown", 1'b0, outputEnable);
		rdchk("oc status", CMD_STATUS_CURRENT, 16'h0080);
		wrchk(CMD_OC_RESPONSE, 16'h0000, 1'b1);
		wrchk(CMD_AVG_OC_LIMIT, 16'h0001, 1'b1);
		for (int m = 0; m < 2; m++) begin
			for (int j = 0; j < 3; j++) begin
				window(1'(m), curs[j], (j == 2) ? 16'h0080 : 16'h0000);
			end
		end
		wrchk(CMD_OC_RESPONSE, 16'h0080, 1'b1);
		window(1'b0, curs[2], 16'h0080);
		chk1("average trip shutdown", 1'b0, outputEnable);
		stop_test();
	end
endmodule : tb_top
